// file: inc/pfs_pkg.sv
// Shared constants for the port-A pin function selector
package pfs_pkg;
  localparam int          FIELD_W      = 3;
  localparam int          PIN_COUNT    = 3;
  localparam int          REG_W        = 11;
  // Field positions inside the control word
  localparam int          PIN12_LSB    = 0;
  localparam int          PIN13_LSB    = 4;
  localparam int          PIN14_LSB    = 8;
  localparam int          RSVD_BIT_A   = 3;
  localparam int          RSVD_BIT_B   = 7;
  // Function codes
  localparam logic [2:0]  FUNC_GPIO    = 3'h0;
  localparam logic [2:0]  FUNC_ADDR    = 3'h4;
  localparam logic [2:0]  FUNC_SYNC    = 3'h5;
  localparam logic [2:0]  FUNC_ASYNC   = 3'h6;
  // Reset values of the two lower field bits
  localparam logic [1:0]  FIELD_LOW_RST = 2'h0;
  // Mask of writable bits, reserved bits excluded
  localparam logic [10:0] WR_MASK      = 11'h777;
  localparam int          SYNC_STAGES  = 2;

  typedef enum logic [3:0]
  {
    SEL_GPIO  = 4'h1,
    SEL_ADDR  = 4'h2,
    SEL_SYNC  = 4'h4,
    SEL_ASYNC = 4'h8
  } pfs_sel_e;
endpackage

// file: hw/pfs_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pfs_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             mclk_in,    // Clock
  input  wire logic             sys_rst_in, // Sync reset, high
  input  wire logic             ce_in,      // Clock enable
  input  wire logic [WIDTH-1:0] async_in,   // Raw pin levels
  output logic      [WIDTH-1:0] sync_out    // Synchronised levels
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // Refused at elaboration: an empty bus has nothing to carry
  if (WIDTH < 1)
  begin : g_bad_width
    $error("pfs_sync: WIDTH must be positive");
  end

  // First stage feeds only the second stage
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else if (ce_in)
    begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;
endmodule

// file: hw/pfs_top.sv
// Port-A pins 12..14 function select and routing
`timescale 1ns/1ps
module pfs_top (
  input  wire logic        mclk_in,                // 20 MHz clock
  input  wire logic        sys_rst_in,             // Sync reset, high
  input  wire logic        ce_in,                  // Clock enable
  input  wire logic        boot_ext_rom_off_in,    // Boot mode strap
  input  wire logic        ctrl_wr_in,             // Control write strobe
  input  wire logic [10:0] ctrl_wdata_in,          // Control write data
  output logic      [10:0] ctrl_rdata_out,         // Control readback
  output logic             sel_fault_out,          // Prohibited code held
  // Pin side: oe_n low drives the pin
  input  wire logic [2:0]  pin_in,                 // Pins 14..12 level
  output logic      [2:0]  pin_out,                // Pins 14..12 drive
  output logic      [2:0]  pin_oe_n_out,           // Pins 14..12 enable_n
  // General I/O port
  input  wire logic [2:0]  gpio_out_in,            // Port output data
  input  wire logic [2:0]  gpio_oe_in,             // Port output enable
  output logic      [2:0]  gpio_in_out,            // Port input data
  // Bus state controller
  input  wire logic [2:0]  ext_addr_bits_in,       // Address bits 10..8
  // Sync serial unit: data, clock, chip select
  input  wire logic [2:0]  sync_ser_out_in,        // Unit output data
  input  wire logic [2:0]  sync_ser_oe_in,         // Unit output enable
  output logic      [2:0]  sync_ser_in_out,        // Unit input data
  // Async serial: rx1, clk1, clk0
  input  wire logic [2:0]  async_ser_out_in,       // Unit output data
  input  wire logic [2:0]  async_ser_oe_in,        // Unit output enable
  output logic      [2:0]  async_ser_in_out        // Unit input data
);
  localparam int FW = pfs_pkg::FIELD_W;
  localparam int NP = pfs_pkg::PIN_COUNT;

  // Port widths and the field map assume three 3-bit fields
  if (FW != 3 || NP != 3 || pfs_pkg::REG_W != 11)
  begin : g_bad_layout
    $error("pfs_top: layout must be three 3-bit fields in 11 bits");
  end

  logic [10:0]   ctrl_r;
  logic [10:0]   ctrl_nxt;
  logic          strap_taken_r;
  logic [NP-1:0] pin_sync;
  logic [NP-1:0] pin_bad;
  logic [NP-1:0] pin_out_nxt;
  logic [NP-1:0] pin_oe_n_nxt;
  logic [NP-1:0] pin_out_r;
  logic [NP-1:0] pin_oe_n_r;
  logic [NP-1:0] gpio_in_r;
  logic [NP-1:0] sync_ser_in_r;
  logic [NP-1:0] async_ser_in_r;
  logic [NP-1:0] gpio_in_nxt;
  logic [NP-1:0] sync_ser_in_nxt;
  logic [NP-1:0] async_ser_in_nxt;

  // Field offset of pin index i (0 = pin 12)
  function automatic int field_lsb(input int i);
    case (i)
      0:       field_lsb = pfs_pkg::PIN12_LSB;
      1:       field_lsb = pfs_pkg::PIN13_LSB;
      default: field_lsb = pfs_pkg::PIN14_LSB;
    endcase
  endfunction

  // Decode a field into a one-hot selection; 0 means prohibited
  function automatic logic [3:0] decode_sel(input logic [2:0] code);
    case (code)
      pfs_pkg::FUNC_GPIO:  decode_sel = pfs_pkg::SEL_GPIO;
      pfs_pkg::FUNC_ADDR:  decode_sel = pfs_pkg::SEL_ADDR;
      pfs_pkg::FUNC_SYNC:  decode_sel = pfs_pkg::SEL_SYNC;
      pfs_pkg::FUNC_ASYNC: decode_sel = pfs_pkg::SEL_ASYNC;
      default:             decode_sel = 4'h0;
    endcase
  endfunction

  // Word loaded once after reset: field MSBs follow the boot strap
  function automatic logic [10:0] strap_word(input logic ext_boot);
    logic [10:0] w;
    w = '0;
    for (int i = 0; i < pfs_pkg::PIN_COUNT; i++)
    begin
      w[field_lsb(i) +: 2] = pfs_pkg::FIELD_LOW_RST;
      w[field_lsb(i) + pfs_pkg::FIELD_W - 1] = ext_boot;
    end
    return w;
  endfunction

  pfs_sync #(
    .WIDTH (NP)
  ) u_pin_sync (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .ce_in      (ce_in),
    .async_in   (pin_in),
    .sync_out   (pin_sync)
  );

  // Reserved bits forced low on every write
  assign ctrl_nxt = ctrl_wdata_in & pfs_pkg::WR_MASK;

  // Strap is a same-domain level; caught on the first enabled edge after reset
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
      strap_taken_r <= 1'b0;
    else if (ce_in)
      strap_taken_r <= 1'b1;
  end

  // A write on the strap edge is dropped so the boot value lands first
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
      ctrl_r <= '0;
    else if (ce_in)
    begin
      if (!strap_taken_r)
        ctrl_r <= strap_word(boot_ext_rom_off_in);
      else if (ctrl_wr_in)
        ctrl_r <= ctrl_nxt;
    end
  end

  // Per-pin routing; index 0/1/2 = pins 12/13/14
  generate
    for (genvar g = 0; g < NP; g++)
    begin : g_pin
      logic [2:0] code;
      logic [3:0] sel;
      assign code = ctrl_r[field_lsb(g) +: FW];
      assign sel  = decode_sel(code);
      assign pin_bad[g] = (sel == 4'h0);

      always_comb
      begin
        pin_out_nxt[g]  = 1'b0;
        pin_oe_n_nxt[g] = 1'b1;
        gpio_in_nxt[g]  = 1'b0;
        sync_ser_in_nxt[g]  = 1'b0;
        async_ser_in_nxt[g] = 1'b0;
        case (sel)
          pfs_pkg::SEL_GPIO:
          begin
            pin_out_nxt[g]  = gpio_out_in[g];
            pin_oe_n_nxt[g] = ~gpio_oe_in[g];
            gpio_in_nxt[g]  = pin_sync[g];
          end
          pfs_pkg::SEL_ADDR:
          begin
            pin_out_nxt[g]  = ext_addr_bits_in[g];
            pin_oe_n_nxt[g] = 1'b0;
          end
          pfs_pkg::SEL_SYNC:
          begin
            pin_out_nxt[g]     = sync_ser_out_in[g];
            pin_oe_n_nxt[g]    = ~sync_ser_oe_in[g];
            sync_ser_in_nxt[g] = pin_sync[g];
          end
          pfs_pkg::SEL_ASYNC:
          begin
            // Receive pin 14 is input only
            pin_out_nxt[g]      = (g == 2) ? 1'b0 : async_ser_out_in[g];
            pin_oe_n_nxt[g]     = (g == 2) ? 1'b1 : ~async_ser_oe_in[g];
            async_ser_in_nxt[g] = pin_sync[g];
          end
          // Prohibited codes leave the pin floating, safest choice
          default:
          begin
            pin_oe_n_nxt[g] = 1'b1;
          end
        endcase
      end
    end
  endgenerate

  // Registered pin drive, one cycle behind the selection
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      pin_out_r  <= '0;
      pin_oe_n_r <= '1;
    end
    else if (ce_in)
    begin
      pin_out_r  <= pin_out_nxt;
      pin_oe_n_r <= pin_oe_n_nxt;
    end
  end

  // Registered unit inputs; pin to unit costs sync plus this stage
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      gpio_in_r      <= '0;
      sync_ser_in_r  <= '0;
      async_ser_in_r <= '0;
    end
    else if (ce_in)
    begin
      gpio_in_r      <= gpio_in_nxt;
      sync_ser_in_r  <= sync_ser_in_nxt;
      async_ser_in_r <= async_ser_in_nxt;
    end
  end

  // Address output in single-chip mode is software's duty, not checked
  assign ctrl_rdata_out   = ctrl_r;
  assign sel_fault_out    = |pin_bad;
  assign pin_out          = pin_out_r;
  assign pin_oe_n_out     = pin_oe_n_r;
  assign gpio_in_out      = gpio_in_r;
  assign sync_ser_in_out  = sync_ser_in_r;
  assign async_ser_in_out = async_ser_in_r;
endmodule

// file: bench/pfs_chk.sv
// Port checks for the pin function selector
`timescale 1ns/1ps
module pfs_chk (
  input wire logic        mclk_in,             // Clock
  input wire logic        sys_rst_in,          // Sync reset, high
  input wire logic        ce_in,               // Clock enable
  input wire logic        boot_ext_rom_off_in, // Boot mode strap
  input wire logic        ctrl_wr_in,          // Control write strobe
  input wire logic [10:0] ctrl_wdata_in,       // Control write data
  input wire logic [10:0] ctrl_rdata_out,      // Control readback
  input wire logic        sel_fault_out,       // Prohibited code held
  input wire logic [2:0]  pin_out,             // Pin drive
  input wire logic [2:0]  pin_oe_n_out,        // Pin enable, low drives
  input wire logic [2:0]  ext_addr_bits_in,    // Address bits 10..8
  input wire logic [2:0]  sync_ser_out_in,     // Sync unit output data
  input wire logic [2:0]  sync_ser_oe_in       // Sync unit output enable
);
  logic       armed_r;
  logic [2:0] bad;
  function automatic logic ill(input logic [2:0] f);
    return !(f inside {3'h0, 3'h4, 3'h5, 3'h6});
  endfunction
  assign bad = {ill(ctrl_rdata_out[10:8]), ill(ctrl_rdata_out[6:4]),
                ill(ctrl_rdata_out[2:0])};
  // First enabled edge takes the strap, not a write
  always_ff @(posedge mclk_in)
    if (sys_rst_in)
      armed_r <= 1'b0;
    else if (ce_in)
      armed_r <= 1'b1;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  a_rsvd_read_zero: assert property (
    !ctrl_rdata_out[7] && !ctrl_rdata_out[3])
    else $error("reserved bit set");
  a_strap_load: assert property (
    ce_in && !armed_r |=> ctrl_rdata_out ==
    (11'h444 & {11{$past(boot_ext_rom_off_in)}})) else $error("bad strap");
  a_write_masked: assert property (ce_in && armed_r && ctrl_wr_in |=>
    ctrl_rdata_out == ($past(ctrl_wdata_in) & 11'h777)) else $error("bad write");
  a_fault_flag: assert property (sel_fault_out == (|bad))
    else $error("fault flag wrong");
  a_bad_release: assert property (ce_in && bad[2] |=> pin_oe_n_out[2])
    else $error("prohibited code drives");
  a_rx1_no_drive: assert property (
    ce_in && ctrl_rdata_out[10:8] == 3'h6 |=> pin_oe_n_out[2])
    else $error("receive pin driven");
  a_addr_pin_drive: assert property (
    ce_in && ctrl_rdata_out[2:0] == 3'h4 |=>
    !pin_oe_n_out[0] && pin_out[0] == $past(ext_addr_bits_in[0]))
    else $error("address not routed");
  a_sync_clk_route: assert property (
    ce_in && ctrl_rdata_out[6:4] == 3'h5 |=>
    pin_out[1] == $past(sync_ser_out_in[1]) &&
    pin_oe_n_out[1] == !$past(sync_ser_oe_in[1]))
    else $error("sync clock lost");
  c_write: cover property (armed_r && ce_in && ctrl_wr_in);
  c_fault: cover property (sel_fault_out);
  c_ext_boot: cover property (ce_in && !armed_r && boot_ext_rom_off_in);
endmodule
bind pfs_top pfs_chk u_pfs_chk (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
  .ce_in(ce_in), .boot_ext_rom_off_in(boot_ext_rom_off_in),
  .ctrl_wr_in(ctrl_wr_in), .ctrl_wdata_in(ctrl_wdata_in),
  .ctrl_rdata_out(ctrl_rdata_out), .sel_fault_out(sel_fault_out),
  .pin_out(pin_out), .pin_oe_n_out(pin_oe_n_out),
  .ext_addr_bits_in(ext_addr_bits_in), .sync_ser_out_in(sync_ser_out_in),
  .sync_ser_oe_in(sync_ser_oe_in));

// file: bench/pfs_periph_model.sv
// Far-side units and resolved pin wire
`timescale 1ns/1ps
module pfs_periph_model (
  input  wire logic        mclk_in,   // Clock
  input  wire logic        step_in,   // Draw new unit values
  input  wire logic [2:0]  drv_in,    // Selector pin drive
  input  wire logic [2:0]  oe_n_in,   // Selector enable, low drives
  output logic      [23:0] unit_out,  // Unit values, outside level on top
  output logic      [2:0]  lvl_out    // Pin wire level
);
  logic [31:0] st_r = 32'h5df3b2b5;
  always @(posedge mclk_in)
    if (step_in)
      st_r <= {st_r[30:0], st_r[31] ^ st_r[21] ^ st_r[1] ^ st_r[0]};
  assign unit_out = st_r[23:0];
  // Released pin follows a changing outside level, never a stale drive
  assign lvl_out = (drv_in & ~oe_n_in) | (st_r[23:21] & oe_n_in);
endmodule

// file: bench/port_a_pin_function_select_tb_top.sv
// Self-checking bench for the pin function selector
`timescale 1ns/1ps
module port_a_pin_function_select_tb_top;
  logic mclk, rst, ce, strap, wr, step;
  logic [10:0] wdata, rdata, word;
  logic fault;
  logic [2:0] lvl, pin_o, oe_n, gpio_in, syn_in, asy_in;
  logic [23:0] u;
  logic [31:0] seed;
  int error_cnt = 0;
  int check_count = 0;
  pfs_top u_pfs_top (.mclk_in(mclk), .sys_rst_in(rst), .ce_in(ce),
    .boot_ext_rom_off_in(strap), .ctrl_wr_in(wr), .ctrl_wdata_in(wdata),
    .ctrl_rdata_out(rdata), .sel_fault_out(fault), .pin_in(lvl),
    .pin_out(pin_o), .pin_oe_n_out(oe_n), .gpio_out_in(u[2:0]),
    .gpio_oe_in(u[5:3]), .gpio_in_out(gpio_in), .ext_addr_bits_in(u[8:6]),
    .sync_ser_out_in(u[11:9]), .sync_ser_oe_in(u[14:12]),
    .sync_ser_in_out(syn_in), .async_ser_out_in(u[17:15]),
    .async_ser_oe_in(u[20:18]), .async_ser_in_out(asy_in));
  pfs_periph_model u_pfs_periph_model (.mclk_in(mclk), .step_in(step),
    .drv_in(pin_o), .oe_n_in(oe_n), .unit_out(u), .lvl_out(lvl));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // High when any field holds a code outside the four allowed ones
  function automatic logic bad_word(input logic [10:0] w);
    logic b;
    b = 1'b0;
    for (int i = 0; i < 3; i++)
      b |= !(w[4*i +: 3] inside {3'h0, 3'h4, 3'h5, 3'h6});
    return b;
  endfunction
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk_pin(input int i, input logic [2:0] c);
    logic d, en, lv;
    d = c == 3'h0 ? u[i] : c == 3'h4 ? u[6+i] : c == 3'h5 ? u[9+i] : u[15+i];
    en = c == 3'h0 ? u[3+i] : c == 3'h4 ? 1'b1 : c == 3'h5 ? u[12+i] :
         (c == 3'h6 && i != 2) ? u[18+i] : 1'b0;
    lv = en ? d : u[21+i];
    check(oe_n[i], !en);
    if (en)
      check(pin_o[i], d);
    check(gpio_in[i], c == 3'h0 ? lv : 1'b0);
    check(syn_in[i], c == 3'h5 ? lv : 1'b0);
    check(asy_in[i], c == 3'h6 ? lv : 1'b0);
  endtask
  // Settle time covers register, routing and the two-flop input path
  task automatic wr_word(input logic [10:0] w);
    @(posedge mclk);
    wr <= 1'b1;
    wdata <= w;
    step <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    step <= 1'b0;
    word = w & 11'h777;
    repeat (8) @(negedge mclk);
    check(rdata, word);
    check(fault, bad_word(word));
    for (int i = 0; i < 3; i++)
      chk_pin(i, word[4*i +: 3]);
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    strap = 1'b0;
    wr = 1'b0;
    step = 1'b0;
    wdata = 11'h0;
    seed = 32'h5df3b2b5;
    for (int r = 0; r < 2; r++)
    begin
      @(posedge mclk);
      rst <= 1'b1;
      strap <= r[0];
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      repeat (3) @(negedge mclk);
      check(rdata, r[0] ? 11'h444 : 11'h0);
    end
    // Extension boot from here, so address codes are allowed
    for (int k = 0; k < 8; k++)
      wr_word({k[2:0], 1'b1, k[2:0], 1'b1, k[2:0]});
    repeat (24)
    begin
      repeat (11) seed = lfsr(seed);
      wr_word(seed[10:0]);
    end
    @(posedge mclk);
    ce <= 1'b0;
    wr <= 1'b1;
    wdata <= ~word;
    @(posedge mclk);
    ce <= 1'b1;
    wr <= 1'b0;
    @(negedge mclk);
    check(rdata, word);
    conclude();
  end
endmodule
